// File: rtl/ptt_pkg.sv
/*
  Shared constants and types of the periodic tick timebase.
  Assumes a single system clock domain and a plain register port.
*/
package ptt_pkg;
  // Register map, one 8-bit control register
  localparam logic [3:0] TICK_CONTROL_ADDR = 4'h0;
  localparam logic [7:0] TICK_CONTROL_RESET = 8'h00;
  // Field positions of tick_control
  localparam int TICK_FLAG_POS = 7;
  localparam int TICK_FLAG_CLEAR_POS = 6;
  localparam int TAP_SELECT_LSB = 3;
  localparam int TICK_IRQ_ENABLE_POS = 2;
  localparam int TICK_RUN_ENABLE_POS = 1;
  // Divider chain
  localparam int CHAIN_STAGES = 15;
  localparam int PRESCALE128_BITS = 7;
  localparam logic [6:0] PRESCALE128_LAST = 7'h7f;

  typedef struct packed {
    logic tickRunEnable;
    logic tickIrqEnable;
    logic [2:0] tapSelect;
  } ptt_ctrl_s;
endpackage

// File: rtl/ptt_sync.sv
/*
  Three-flop synchroniser for an outside level.
  Assumes the input is asynchronous to sys_clk; the change counts when stages two and three agree.
*/
`timescale 1ns/100ps
module ptt_sync (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic asyncIn,
  output logic syncOut
);
  logic [2:0] stage;
  logic next_syncOut;

  // Hold the output until the last two stages agree
  always_comb begin
    next_syncOut = syncOut;
    if (stage[1] == stage[2]) begin
      next_syncOut = stage[2];
    end
  end

  // Shift chain and output register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      stage <= 3'h0;
      syncOut <= 1'b0;
    end else begin
      stage <= {stage[1:0], asyncIn};
      syncOut <= next_syncOut;
    end
  end
endmodule

// File: rtl/ptt_timebase.sv
/*
  Periodic tick timebase: prescaler, 15-stage divider, tick flag and control register.
  Assumes osc_ref_clock arrives as an asynchronous pin slower than sys_clk / 3,
  low-power mode levels come from the clock generator on sys_clk, config straps are static.
*/
`timescale 1ns/100ps
module ptt_timebase #(
  parameter int STAGES = ptt_pkg::CHAIN_STAGES
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic osc_ref_clock,
  input wire logic prescale128_select,
  input wire logic osc_run_in_stop,
  input wire logic waitMode,
  input wire logic stopMode,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  output logic tickIrq
);
  ptt_pkg::ptt_ctrl_s ctrl;
  ptt_pkg::ptt_ctrl_s next_ctrl;
  logic tick_flag;
  logic next_tick_flag;
  logic [7:0] next_regRdata;
  logic [STAGES-1:0] chain;
  logic [STAGES-1:0] next_chain;
  logic [ptt_pkg::PRESCALE128_BITS-1:0] prescale;
  logic [ptt_pkg::PRESCALE128_BITS-1:0] next_prescale;
  logic oscLevel;
  logic oscLevelLast;
  logic oscRise;
  logic tick_source_clock;
  logic active;
  logic busOpen;
  logic rollover;
  logic [STAGES-1:0] chainInc;

  // Tap bit index of the chain for each select code
  function automatic int tapBit(input logic [2:0] sel);
    case (sel)
      3'h0: tapBit = 14;
      3'h1: tapBit = 12;
      3'h2: tapBit = 10;
      3'h3: tapBit = 6;
      3'h4: tapBit = 5;
      3'h5: tapBit = 4;
      3'h6: tapBit = 3;
      default: tapBit = 2;
    endcase
  endfunction

  // Reference clock pin brought into sys_clk domain
  ptt_sync oscSync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .asyncIn(osc_ref_clock),
    .syncOut(oscLevel)
  );

  // Activity and register reach in low-power modes
  assign active = !stopMode || osc_run_in_stop;
  assign busOpen = !waitMode && !stopMode;
  assign oscRise = oscLevel && !oscLevelLast && active;

  // Optional divide-by-128 ahead of the chain
  always_comb begin
    next_prescale = prescale;
    tick_source_clock = oscRise;
    if (!ctrl.tickRunEnable || !prescale128_select) begin
      next_prescale = '0;
    end else if (oscRise) begin
      next_prescale = prescale + 7'h01;
    end
    if (prescale128_select) begin
      tick_source_clock = oscRise && (prescale == ptt_pkg::PRESCALE128_LAST);
    end
  end

  // Divider chain; the tap rolls over when its bit rises
  always_comb begin
    chainInc = chain + {{(STAGES-1){1'b0}}, 1'b1};
    next_chain = chain;
    rollover = 1'b0;
    if (!ctrl.tickRunEnable) begin
      next_chain = '0;
    end else if (tick_source_clock) begin
      next_chain = chainInc;
      // A tap bit rising from zero to one marks each period; the first comes
      // after half a period since the chain starts at zero
      rollover = !chain[tapBit(ctrl.tapSelect)] && chainInc[tapBit(ctrl.tapSelect)];
    end
  end

  // Control register writes and the tick flag
  always_comb begin
    next_ctrl = ctrl;
    next_tick_flag = tick_flag;
    if (regWrite && busOpen && regAddr == ptt_pkg::TICK_CONTROL_ADDR) begin
      next_ctrl.tickRunEnable = regWdata[ptt_pkg::TICK_RUN_ENABLE_POS];
      next_ctrl.tickIrqEnable = regWdata[ptt_pkg::TICK_IRQ_ENABLE_POS];
      next_ctrl.tapSelect = regWdata[ptt_pkg::TAP_SELECT_LSB +: 3];
      if (regWdata[ptt_pkg::TICK_FLAG_CLEAR_POS]) begin
        next_tick_flag = 1'b0;
      end
    end
    if (rollover) begin
      next_tick_flag = 1'b1;
    end
  end

  // Read data the cycle after a read strobe; other addresses read zero
  always_comb begin
    next_regRdata = 8'h00;
    if (regRead && busOpen && regAddr == ptt_pkg::TICK_CONTROL_ADDR) begin
      next_regRdata[ptt_pkg::TICK_FLAG_POS] = tick_flag;
      next_regRdata[ptt_pkg::TAP_SELECT_LSB +: 3] = ctrl.tapSelect;
      next_regRdata[ptt_pkg::TICK_IRQ_ENABLE_POS] = ctrl.tickIrqEnable;
      next_regRdata[ptt_pkg::TICK_RUN_ENABLE_POS] = ctrl.tickRunEnable; // clear bit reads zero
    end
  end

  // State registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl <= ptt_pkg::ptt_ctrl_s'(5'h00);
      tick_flag <= 1'b0;
      chain <= '0;
      prescale <= '0;
      oscLevelLast <= 1'b0;
      regRdata <= ptt_pkg::TICK_CONTROL_RESET;
      tickIrq <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      tick_flag <= next_tick_flag;
      chain <= next_chain;
      prescale <= next_prescale;
      oscLevelLast <= oscLevel;
      regRdata <= next_regRdata;
      tickIrq <= next_tick_flag && next_ctrl.tickIrqEnable;
    end
  end
endmodule

// File: bench/ptt_timebase_sva.sv
/* Port checker of the tick timebase.
   Assumes it is bound to every ptt_timebase. */
`timescale 1ns/100ps
module ptt_timebase_sva (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic osc_run_in_stop,
  input wire logic waitMode,
  input wire logic stopMode,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdata,
  input wire logic tickIrq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // Access that the register port accepts
  wire logic busOpen = regAddr == 4'h0 && !waitMode && !stopMode;
  wire logic ackWr = regWrite && busOpen && regWdata[6];
  a_rdata_idle: assert property (!regRead |=> regRdata == 8'h00)
    else $error("read data not idle");
  a_ack_reads_zero: assert property (regRead |=> !regRdata[6] && !regRdata[0])
    else $error("write-only bit read back");
  a_lock_read: assert property (regRead && !busOpen |=> regRdata == 8'h00)
    else $error("locked read returned data");
  a_irq_matches: assert property (regRead && busOpen |=> $past(tickIrq) == (regRdata[7] & regRdata[2]))
    else $error("irq differs from flag and enable");
  a_irq_off_write: assert property (regWrite && busOpen && !regWdata[2] |=> !tickIrq)
    else $error("irq with enable written low");
  a_irq_sticky: assert property (tickIrq && !(regWrite && busOpen) |=> tickIrq)
    else $error("irq dropped without write");
  a_stop_frozen: assert property (stopMode && !osc_run_in_stop && !tickIrq |=> !tickIrq)
    else $error("irq rose in frozen stop");
  a_ack_clears: assert property (ackWr && !regWdata[1] ##2 ackWr |=> !tickIrq)
    else $error("flag not cleared");
  // Main scenarios reached
  cover property ($rose(tickIrq));
  cover property (regRead && waitMode);
  cover property (stopMode && osc_run_in_stop && $rose(tickIrq));
endmodule
bind ptt_timebase ptt_timebase_sva chk (.sys_clk(sys_clk), .resetn(resetn), .osc_run_in_stop(osc_run_in_stop),
  .waitMode(waitMode), .stopMode(stopMode), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
  .regRead(regRead), .regRdata(regRdata), .tickIrq(tickIrq));

// File: bench/periodic_tick_timebase_tb.sv
/* Testbench of the tick timebase: tap periods, prescale, lockouts.
   Assumes the checker binds itself to the design. */
`timescale 1ns/100ps
`define CHK(a, e) begin checkCount++; if ((a) !== (e)) begin nFail++; $display("Error %0t %h %h", $time, a, e); end end
module periodic_tick_timebase_tb;
  logic sys_clk = 0, resetn = 0, oscRef = 0, pre = 0, oscStop = 0, waitMode = 0, stopMode = 0;
  logic regWrite = 0, regRead = 0, tickIrq;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00, regRdata, rd, rd2;
  int nFail = 0, checkCount = 0, got;
  // Bus clock and a slower reference pin
  always #12.5 sys_clk = ~sys_clk;
  always #150 oscRef = ~oscRef;
  ptt_timebase dut (.sys_clk(sys_clk), .resetn(resetn), .osc_ref_clock(oscRef), .prescale128_select(pre),
    .osc_run_in_stop(oscStop), .waitMode(waitMode), .stopMode(stopMode), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .tickIrq(tickIrq));
  task automatic finishTest;
    $display("Checks %0d errors %0d", checkCount, nFail);
    if (nFail == 0 && checkCount > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rdx(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    @(negedge sys_clk);
    d = regRdata;
  endtask
  // Count pin rises until the irq shows, bounded
  task automatic rises(output int c);
    c = 0;
    @(negedge sys_clk);
    while (tickIrq !== 1'b1 && c < 5000) begin
      @(posedge oscRef or posedge tickIrq);
      if (tickIrq !== 1'b1) c++;
    end
    if (c >= 5000) begin
      nFail++;
      finishTest();
    end
  endtask
  function automatic int period(input logic [2:0] c, input logic p);
    int t[8] = '{32768, 8192, 2048, 128, 64, 32, 16, 8};
    return p ? t[c] * 128 : t[c];
  endfunction
  // Half period first, then full period, then readback
  task automatic runTap(input logic [2:0] c, input logic p);
    pre <= p;
    wr(4'h0, {2'b01, c, 3'b100});
    wr(4'h0, {2'b01, c, 3'b100});
    @(negedge oscRef);
    wr(4'h0, {2'b00, c, 3'b110});
    rises(got);
    `CHK(got, period(c, p) / 2)
    wr(4'h0, {2'b01, c, 3'b110});
    rises(got);
    `CHK(got, period(c, p))
    rdx(4'h0, rd);
    `CHK(rd, {2'b10, c, 3'b110})
  endtask
  // Main sequence
  initial begin
    void'($urandom(32'hc9507c56));
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    rdx(4'h0, rd);
    `CHK(rd, 8'h00)
    for (int i = 2; i < 8; i++) runTap(3'(i), 1'b0);
    runTap(3'h7, 1'b1);
    runTap(3'($urandom_range(7, 3)), 1'b0);
    wr(4'($urandom_range(15, 1)), 8'($urandom));
    rdx(4'h0, rd2);
    `CHK(rd2, rd)
    wr(4'h0, rd | 8'h40);
    waitMode <= 1'b1;
    rdx(4'h0, rd);
    `CHK(rd, 8'h00)
    rises(got);
    wr(4'h0, 8'h40);
    @(negedge sys_clk);
    `CHK(tickIrq, 1'b1)
    waitMode <= 1'b0;
    wr(4'h0, rd2 | 8'h40);
    stopMode <= 1'b1;
    repeat (1600) @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK(tickIrq, 1'b0)
    oscStop <= 1'b1;
    rises(got);
    `CHK(tickIrq, 1'b1)
    finishTest();
  end
endmodule
